// file: verilog/clk_dist_pkg.sv
// Package: register map, field layout, reset values and encodings
package clk_dist_pkg;
	// Printed offsets are not multiples of four: they are indices, byte address = 4 * index
	localparam logic [11:0] IDX_DIST_SETTINGS = 12'h400;
	localparam logic [11:0] IDX_DRIVER_ENABLE = 12'h401;
	localparam logic [11:0] IDX_SYNC_CONTROL = 12'h402;
	localparam logic [11:0] IDX_AUTO_SYNC = 12'h403;
	localparam logic [11:0] IDX_CLOCK_OUTPUT_ZERO_MODE = 12'h404;
	// Own registers: channel zero divider value and sync command/status
	localparam logic [11:0] IDX_DIV0_VALUE = 12'h408;
	localparam logic [11:0] IDX_SYNC_STATUS = 12'h420;
	// Writable bit masks; other bits read zero
	localparam logic [7:0] MASK_DIST_SETTINGS = 8'h3f;
	localparam logic [7:0] MASK_DRIVER_ENABLE = 8'h0f;
	localparam logic [7:0] MASK_SYNC_CONTROL = 8'h3f;
	localparam logic [7:0] MASK_AUTO_SYNC = 8'h03;
	localparam logic [7:0] MASK_CLOCK_OUTPUT_ZERO_MODE = 8'h3f;
	localparam logic [29:0] MASK_DIV0 = 30'h3fffffff;
	// Reset values
	localparam logic [7:0] RST_DIST_SETTINGS = 8'h00;
	localparam logic [7:0] RST_DRIVER_ENABLE = 8'h00;
	localparam logic [7:0] RST_SYNC_CONTROL = 8'h00;
	localparam logic [7:0] RST_AUTO_SYNC = 8'h00;
	localparam logic [7:0] RST_CLOCK_OUTPUT_ZERO_MODE = 8'h03;
	localparam logic [29:0] RST_DIV0 = 30'h0;
	// Field positions
	localparam int POS_RX_MODE = 4;
	localparam int POS_EXT_RES = 5;
	localparam int POS_SYNC_SRC = 4;
	localparam int POS_DRIVE = 3;
	localparam int POS_POL_INV = 4;
	localparam int POS_PHASE_INV = 5;
	localparam logic [3:0] ALL_DOWN = 4'hf;
	// Sync source codes
	localparam logic [1:0] SRC_DIRECT = 2'h0;
	localparam logic [1:0] SRC_ACTIVE_REF = 2'h1;
	localparam logic [1:0] SRC_FEEDBACK = 2'h2;
	// Auto sync codes
	localparam logic [1:0] AUTO_OFF = 2'h0;
	localparam logic [1:0] AUTO_FREQ = 2'h1;
	localparam logic [1:0] AUTO_PHASE = 2'h2;
	// Output mode codes
	localparam logic [2:0] MODE_CMOS_BOTH = 3'h0;
	localparam logic [2:0] MODE_CMOS_POS = 3'h1;
	localparam logic [2:0] MODE_CMOS_NEG = 3'h2;
	localparam logic [2:0] MODE_TRI_BOTH = 3'h3;
	localparam logic [2:0] MODE_LVDS = 3'h4;
	localparam logic [2:0] MODE_LVPECL = 3'h5;
	// Sync arming states
	typedef enum logic [2:0] {
		SYNC_IDLE = 3'b001,
		SYNC_ARMED = 3'b010,
		SYNC_FIRE = 3'b100
	} sync_state_e;
endpackage : clk_dist_pkg

// file: verilog/clock_output_distribution_ctrl.sv
// Clock distribution control: APB registers, driver gating, divider sync, output zero pins
//
// Operation
// - Per-channel power-down bit, one powers down
// - All four powered down enters deep sleep
// - Per-driver enable, reset disabled
// - Sync source: direct, active reference, feedback
// - Mask bit makes divider ignore sync reset
// - Auto sync on frequency or phase lock
// - Output zero CMOS and tristate pin modes
// - Output zero LVDS, LVPECL; 110/111 reserved
// - Polarity invert bit flips output zero
// - CMOS phase invert only in CMOS modes
// - Drive strength bit selects drive level
// - Receiver super-Nyquist mode bit
// - External or internal current resistor select
// - Divider value zero means divide by one
`timescale 1ns/1ns
module clock_output_distribution_ctrl #(
	parameter int CHANNELS = 4,
	parameter int DIV_WIDTH = 30
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [13:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic dist_clk,
	input wire logic active_ref_edge,
	input wire logic feedback_edge,
	input wire logic freq_lock,
	input wire logic phase_lock,
	output logic [3:0] channel_power_down,
	output logic deep_sleep,
	output logic [3:0] driver_enable,
	output logic [3:0] divider_sync_reset,
	output logic receiver_super_nyquist,
	output logic external_resistor,
	output logic zero_pos_data,
	output logic zero_neg_data,
	output logic zero_pos_oe_n,
	output logic zero_neg_oe_n,
	output logic zero_lvds,
	output logic zero_lvpecl,
	output logic zero_drive_high
);
	logic [7:0] dist_settings_reg;
	logic [7:0] driver_enable_reg;
	logic [7:0] sync_control_reg;
	logic [7:0] auto_sync_reg;
	logic [7:0] clock_output_zero_mode_reg;
	logic [DIV_WIDTH-1:0] div0_reg;
	logic [DIV_WIDTH-1:0] div0_count_reg;
	logic clk_clock_output_zero_reg;
	logic [2:0] dist_clk_sync;
	logic [1:0] ref_sync;
	logic [1:0] fb_sync;
	logic [1:0] flock_sync;
	logic [1:0] plock_sync;
	logic ref_prev;
	logic fb_prev;
	logic flock_prev;
	logic plock_prev;
	logic sync_cmd;
	logic sync_event;
	logic source_edge;
	logic auto_trigger;
	logic sync_done_reg;
	logic wr_en;
	logic rd_en;
	logic [11:0] idx;
	logic addr_ok;
	logic [31:0] rd_next;
	logic pin_pos;
	logic pin_neg;
	logic is_cmos;
	clk_dist_pkg::sync_state_e sync_state_reg;

	// Word-indexed decode; low two address bits must be zero
	assign idx = paddr[13:2];
	assign wr_en = clk_en && psel && penable && pwrite && pready;
	assign rd_en = clk_en && psel && !penable && !pwrite;
	assign sync_cmd = wr_en && addr_ok && (idx == clk_dist_pkg::IDX_SYNC_STATUS) && pwdata[0];

	// Address decode and read mux
	always_comb begin
		addr_ok = 1'b1;
		rd_next = 32'h0;
		if (paddr[1:0] != 2'h0) begin
			addr_ok = 1'b0;
		end else if (idx == clk_dist_pkg::IDX_DIST_SETTINGS) begin
			rd_next = {24'h0, dist_settings_reg};
		end else if (idx == clk_dist_pkg::IDX_DRIVER_ENABLE) begin
			rd_next = {24'h0, driver_enable_reg};
		end else if (idx == clk_dist_pkg::IDX_SYNC_CONTROL) begin
			rd_next = {24'h0, sync_control_reg};
		end else if (idx == clk_dist_pkg::IDX_AUTO_SYNC) begin
			rd_next = {24'h0, auto_sync_reg};
		end else if (idx == clk_dist_pkg::IDX_CLOCK_OUTPUT_ZERO_MODE) begin
			rd_next = {24'h0, clock_output_zero_mode_reg};
		end else if (idx == clk_dist_pkg::IDX_DIV0_VALUE) begin
			rd_next = {{(32-DIV_WIDTH){1'b0}}, div0_reg};
		end else if (idx == clk_dist_pkg::IDX_SYNC_STATUS) begin
			rd_next = {29'h0, deep_sleep, sync_done_reg, 1'b0};
		end else begin
			addr_ok = 1'b0;
		end
	end

	// Bus answer: ready in the first access cycle, no wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else if (clk_en) begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !addr_ok;
			if (rd_en) begin
				prdata <= addr_ok ? rd_next : 32'h0;
			end
		end
	end

	// Register writes; unused bits masked off so they never store
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dist_settings_reg <= clk_dist_pkg::RST_DIST_SETTINGS;
			driver_enable_reg <= clk_dist_pkg::RST_DRIVER_ENABLE;
			sync_control_reg <= clk_dist_pkg::RST_SYNC_CONTROL;
			auto_sync_reg <= clk_dist_pkg::RST_AUTO_SYNC;
			clock_output_zero_mode_reg <= clk_dist_pkg::RST_CLOCK_OUTPUT_ZERO_MODE;
			div0_reg <= DIV_WIDTH'(clk_dist_pkg::RST_DIV0);
		end else if (wr_en && addr_ok) begin
			if (idx == clk_dist_pkg::IDX_DIST_SETTINGS) begin
				dist_settings_reg <= pwdata[7:0] & clk_dist_pkg::MASK_DIST_SETTINGS;
			end else if (idx == clk_dist_pkg::IDX_DRIVER_ENABLE) begin
				driver_enable_reg <= pwdata[7:0] & clk_dist_pkg::MASK_DRIVER_ENABLE;
			end else if (idx == clk_dist_pkg::IDX_SYNC_CONTROL) begin
				sync_control_reg <= pwdata[7:0] & clk_dist_pkg::MASK_SYNC_CONTROL;
			end else if (idx == clk_dist_pkg::IDX_AUTO_SYNC) begin
				auto_sync_reg <= pwdata[7:0] & clk_dist_pkg::MASK_AUTO_SYNC;
			end else if (idx == clk_dist_pkg::IDX_CLOCK_OUTPUT_ZERO_MODE) begin
				clock_output_zero_mode_reg <= pwdata[7:0] & clk_dist_pkg::MASK_CLOCK_OUTPUT_ZERO_MODE;
			end else if (idx == clk_dist_pkg::IDX_DIV0_VALUE) begin
				div0_reg <= pwdata[DIV_WIDTH-1:0] & DIV_WIDTH'(clk_dist_pkg::MASK_DIV0);
			end
		end
	end

	// Pin and lock inputs come from other domains: two flops before use
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dist_clk_sync <= 3'h0;
			ref_sync <= 2'h0;
			fb_sync <= 2'h0;
			flock_sync <= 2'h0;
			plock_sync <= 2'h0;
			ref_prev <= 1'b0;
			fb_prev <= 1'b0;
			flock_prev <= 1'b0;
			plock_prev <= 1'b0;
		end else if (clk_en) begin
			dist_clk_sync <= {dist_clk_sync[1:0], dist_clk};
			ref_sync <= {ref_sync[0], active_ref_edge};
			fb_sync <= {fb_sync[0], feedback_edge};
			flock_sync <= {flock_sync[0], freq_lock};
			plock_sync <= {plock_sync[0], phase_lock};
			ref_prev <= ref_sync[1];
			fb_prev <= fb_sync[1];
			flock_prev <= flock_sync[1];
			plock_prev <= plock_sync[1];
		end
	end

	// Auto sync fires once on the rising edge of the chosen lock
	always_comb begin
		case (auto_sync_reg[1:0])
			clk_dist_pkg::AUTO_FREQ: auto_trigger = flock_sync[1] && !flock_prev;
			clk_dist_pkg::AUTO_PHASE: auto_trigger = plock_sync[1] && !plock_prev;
			default: auto_trigger = 1'b0;
		endcase
	end

	// Selected source edge; reserved code never releases a sync
	always_comb begin
		case (sync_control_reg[clk_dist_pkg::POS_SYNC_SRC +: 2])
			clk_dist_pkg::SRC_DIRECT: source_edge = 1'b1;
			clk_dist_pkg::SRC_ACTIVE_REF: source_edge = ref_sync[1] && !ref_prev;
			clk_dist_pkg::SRC_FEEDBACK: source_edge = fb_sync[1] && !fb_prev;
			default: source_edge = 1'b0;
		endcase
	end

	// Request arms, then the source edge fires the sync
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_state_reg <= clk_dist_pkg::SYNC_IDLE;
		end else if (clk_en) begin
			case (sync_state_reg)
				clk_dist_pkg::SYNC_IDLE: begin
					if (sync_cmd || auto_trigger) begin
						sync_state_reg <= clk_dist_pkg::SYNC_ARMED;
					end
				end
				clk_dist_pkg::SYNC_ARMED: begin
					if (source_edge) begin
						sync_state_reg <= clk_dist_pkg::SYNC_FIRE;
					end
				end
				default: sync_state_reg <= clk_dist_pkg::SYNC_IDLE;
			endcase
		end
	end
	assign sync_event = (sync_state_reg == clk_dist_pkg::SYNC_FIRE);

	// Sync-done flag: set wins over clear by a write of one to bit 1
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_done_reg <= 1'b0;
		end else if (clk_en) begin
			if (sync_event) begin
				sync_done_reg <= 1'b1;
			end else if (wr_en && addr_ok && (idx == clk_dist_pkg::IDX_SYNC_STATUS)
				&& pwdata[1]) begin
				sync_done_reg <= 1'b0;
			end
		end
	end

	// Channel zero divider on the sampled distribution clock; value zero passes through
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div0_count_reg <= '0;
			clk_clock_output_zero_reg <= 1'b0;
		end else if (clk_en) begin
			if (sync_event && !sync_control_reg[0]) begin
				div0_count_reg <= '0;
				clk_clock_output_zero_reg <= 1'b0;
			end else if (div0_reg == '0) begin
				clk_clock_output_zero_reg <= dist_clk_sync[1];
			end else if (dist_clk_sync[1] && !dist_clk_sync[2]) begin
				if (div0_count_reg >= div0_reg) begin
					div0_count_reg <= '0;
					clk_clock_output_zero_reg <= !clk_clock_output_zero_reg;
				end else begin
					div0_count_reg <= div0_count_reg + 1'b1;
				end
			end
		end
	end

	// Output zero pin logic; phase invert acts only in CMOS modes
	assign is_cmos = (clock_output_zero_mode_reg[2:0] == clk_dist_pkg::MODE_CMOS_BOTH)
		|| (clock_output_zero_mode_reg[2:0] == clk_dist_pkg::MODE_CMOS_POS)
		|| (clock_output_zero_mode_reg[2:0] == clk_dist_pkg::MODE_CMOS_NEG);
	assign pin_pos = clk_clock_output_zero_reg ^ clock_output_zero_mode_reg[clk_dist_pkg::POS_POL_INV];
	assign pin_neg = is_cmos ? (pin_pos ^ clock_output_zero_mode_reg[clk_dist_pkg::POS_PHASE_INV])
		: !pin_pos;

	// Registered control outputs; drivers gated by power-down and enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			channel_power_down <= 4'h0;
			deep_sleep <= 1'b0;
			driver_enable <= 4'h0;
			divider_sync_reset <= 4'h0;
			receiver_super_nyquist <= 1'b0;
			external_resistor <= 1'b0;
			zero_pos_data <= 1'b0;
			zero_neg_data <= 1'b0;
			zero_pos_oe_n <= 1'b1;
			zero_neg_oe_n <= 1'b1;
			zero_lvds <= 1'b0;
			zero_lvpecl <= 1'b0;
			zero_drive_high <= 1'b0;
		end else if (clk_en) begin
			channel_power_down <= dist_settings_reg[3:0];
			deep_sleep <= (dist_settings_reg[3:0] == clk_dist_pkg::ALL_DOWN);
			driver_enable <= driver_enable_reg[3:0] & ~dist_settings_reg[3:0];
			divider_sync_reset <= {4{sync_event}} & ~sync_control_reg[3:0];
			receiver_super_nyquist <= dist_settings_reg[clk_dist_pkg::POS_RX_MODE];
			external_resistor <= dist_settings_reg[clk_dist_pkg::POS_EXT_RES];
			zero_drive_high <= clock_output_zero_mode_reg[clk_dist_pkg::POS_DRIVE];
			zero_pos_data <= pin_pos;
			zero_neg_data <= pin_neg;
			// Pins float unless the channel is enabled and awake
			zero_pos_oe_n <= !(driver_enable_reg[0] && !dist_settings_reg[0]
				&& (clock_output_zero_mode_reg[2:0] == clk_dist_pkg::MODE_CMOS_BOTH
				|| clock_output_zero_mode_reg[2:0] == clk_dist_pkg::MODE_CMOS_POS));
			zero_neg_oe_n <= !(driver_enable_reg[0] && !dist_settings_reg[0]
				&& (clock_output_zero_mode_reg[2:0] == clk_dist_pkg::MODE_CMOS_BOTH
				|| clock_output_zero_mode_reg[2:0] == clk_dist_pkg::MODE_CMOS_NEG));
			// Reserved codes 110/111 leave every driver off
			zero_lvds <= driver_enable_reg[0] && !dist_settings_reg[0]
				&& (clock_output_zero_mode_reg[2:0] == clk_dist_pkg::MODE_LVDS);
			zero_lvpecl <= driver_enable_reg[0] && !dist_settings_reg[0]
				&& (clock_output_zero_mode_reg[2:0] == clk_dist_pkg::MODE_LVPECL);
		end
	end

	// Checks
	power_down_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en |=> channel_power_down == $past(dist_settings_reg[3:0]))
		else $error("power-down output wrong");
	deep_sleep_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && dist_settings_reg[3:0] == 4'hf |=> deep_sleep)
		else $error("deep sleep missed");
	driver_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		driver_enable_reg[0] == 1'b0 && clk_en |=> !driver_enable[0])
		else $error("disabled driver on");
	source_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
		sync_state_reg == clk_dist_pkg::SYNC_ARMED && !source_edge && clk_en
		|=> !sync_event)
		else $error("sync fired without source edge");
	sync_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && sync_event && sync_control_reg[2] |=> !divider_sync_reset[2])
		else $error("masked divider got sync");
	auto_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		auto_sync_reg[1:0] == 2'h0 |-> !auto_trigger)
		else $error("auto sync while disabled");
	tristate_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && clock_output_zero_mode_reg[2:0] == 3'h3 |=> zero_pos_oe_n && zero_neg_oe_n)
		else $error("tristate mode drives");
	reserved_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && clock_output_zero_mode_reg[2:1] == 2'h3 |=> !zero_lvds && !zero_lvpecl)
		else $error("reserved mode drives");
	phase_inv_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && !is_cmos |=> zero_neg_data != zero_pos_data)
		else $error("phase invert in differential mode");
	sync_cov: cover property (@(posedge pclk) disable iff (!presetn) sync_event);
	auto_cov: cover property (@(posedge pclk) disable iff (!presetn) auto_trigger);
	phase_cov: cover property (@(posedge pclk) disable iff (!presetn) is_cmos && clock_output_zero_mode_reg[5]);
	sleep_cov: cover property (@(posedge pclk) disable iff (!presetn) deep_sleep);
	lvds_cov: cover property (@(posedge pclk) disable iff (!presetn) zero_lvds);
endmodule : clock_output_distribution_ctrl

// file: test/clk_receiver_model.sv
// Downstream receiver model for the two output zero pins
`timescale 1ns/1ns
module clk_receiver_model (
	input wire logic pclk,
	input wire logic pos_data,
	input wire logic neg_data,
	input wire logic pos_oe_n,
	input wire logic neg_oe_n,
	output logic pos_level,
	output logic neg_level
);
	logic pos_last;
	logic neg_last;

	// Remember the last driven value of each pin
	always_ff @(posedge pclk) begin
		if (!pos_oe_n) pos_last <= pos_data;
		if (!neg_oe_n) neg_last <= neg_data;
	end

	// A released pin has no keeper: show the inverse, never a stale copy
	assign pos_level = pos_oe_n ? ~pos_last : pos_data;
	assign neg_level = neg_oe_n ? ~neg_last : neg_data;
endmodule : clk_receiver_model

// file: test/tb_top.sv
// Self-checking bench for the clock distribution control block
`timescale 1ns/1ns
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin err_count++; \
	$display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_top;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic clk_en = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [13:0] paddr = 14'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, dist_clk = 1'b0, clr = 1'b0;
	logic [3:0] trig_in = 4'h0; // Reference, feedback, freq lock, phase lock
	logic [3:0] channel_power_down, driver_enable, divider_sync_reset, seen;
	logic deep_sleep, receiver_super_nyquist, external_resistor;
	logic zero_pos_data, zero_neg_data, zero_pos_oe_n, zero_neg_oe_n;
	logic zero_lvds, zero_lvpecl, zero_drive_high, pos_level, neg_level;
	// Model of the five bytes and their writable bits
	logic [7:0] mdl [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h03};
	logic [7:0] msk [5] = '{8'h3f, 8'h0f, 8'h3f, 8'h03, 8'h3f};
	int err_count = 0;
	int tests_run = 0;
	int seed = 32'hfebb3c20;

	initial begin
		forever #25 pclk = ~pclk;
	end

	clock_output_distribution_ctrl i_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .dist_clk(dist_clk),
		.active_ref_edge(trig_in[0]), .feedback_edge(trig_in[1]), .freq_lock(trig_in[2]),
		.phase_lock(trig_in[3]), .channel_power_down(channel_power_down),
		.deep_sleep(deep_sleep), .driver_enable(driver_enable),
		.divider_sync_reset(divider_sync_reset), .receiver_super_nyquist(receiver_super_nyquist),
		.external_resistor(external_resistor), .zero_pos_data(zero_pos_data),
		.zero_neg_data(zero_neg_data), .zero_pos_oe_n(zero_pos_oe_n),
		.zero_neg_oe_n(zero_neg_oe_n), .zero_lvds(zero_lvds), .zero_lvpecl(zero_lvpecl),
		.zero_drive_high(zero_drive_high));

	clk_receiver_model i_rx (.pclk(pclk), .pos_data(zero_pos_data), .neg_data(zero_neg_data),
		.pos_oe_n(zero_pos_oe_n), .neg_oe_n(zero_neg_oe_n), .pos_level(pos_level),
		.neg_level(neg_level));

	// Sync pulses are short: collect them so none slips between tasks
	always @(posedge pclk) begin
		seen <= clr ? 4'h0 : (seen | divider_sync_reset);
	end

	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : end_sim

	// One APB transfer; holds the request until pready is sampled high
	task automatic apb(input logic wr, input logic [13:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic er);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			$display("[FAIL] pready exp 1 got none");
			err_count++;
			end_sim();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic wr(input logic [11:0] idx, input logic [31:0] d);
		logic [31:0] rd;
		logic er;
		apb(1'b1, {idx, 2'b00}, d, rd, er);
	endtask : wr

	task automatic rchk(input logic [13:0] a, input logic [31:0] ex, input logic xe, string nm);
		logic [31:0] rd;
		logic er;
		apb(1'b0, a, 32'h0, rd, er);
		`CHK(nm, ex, rd)
		`CHK("pslverr", xe, er)
	endtask : rchk

	// Level outputs against the register model
	task automatic chk_outs();
		// Outputs are registered: let the edge after the write pass first
		@(posedge pclk);
		`CHK("pdown", mdl[0][3:0], channel_power_down)
		`CHK("sleep", mdl[0][3:0] == 4'hf, deep_sleep)
		`CHK("drv_en", mdl[1][3:0] & ~mdl[0][3:0], driver_enable)
		`CHK("nyquist", mdl[0][4], receiver_super_nyquist)
		`CHK("ext_res", mdl[0][5], external_resistor)
	endtask : chk_outs

	// One sync case: source, auto mode, mask and trigger kind
	task automatic sync_run(input int s, input int a, input int mk, input int t);
		logic [3:0] ex;
		logic fired;
		fired = t < 3 || (t == 3 && a == 1) || (t == 4 && a == 2);
		ex = fired ? ~4'(mk) : 4'h0;
		wr(12'h402, (s << 4) | mk);
		wr(12'h403, a);
		clr <= 1'b1;
		@(posedge pclk);
		clr <= 1'b0;
		if (t < 3) wr(12'h420, 32'h1);
		if (t > 0) begin
			repeat (6) @(posedge pclk);
			`CHK("early", 4'h0, seen)
			trig_in[t - 1] <= 1'b1;
		end
		repeat (12) @(posedge pclk);
		`CHK("sync", ex, seen)
		rchk(14'h1080, {29'h0, 1'b0, fired, 1'b0}, 1'b0, "done");
		trig_in <= 4'h0;
		wr(12'h420, 32'h2);
		wr(12'h403, 32'h0);
		repeat (4) @(posedge pclk);
	endtask : sync_run

	initial begin
		int k;
		logic [31:0] d;
		logic [2:0] md;
		logic pol, ph, rel;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (k = 0; k < 5; k++) rchk(14'h1000 + 14'(4 * k), {24'h0, mdl[k]}, 1'b0, "reset");
		rchk(14'h1020, 32'h0, 1'b0, "div0");
		chk_outs();
		`CHK("oe_rst", 2'b11, {zero_pos_oe_n, zero_neg_oe_n})
		$display("test reset done");
		// Random bytes into random registers, read back through the masks
		for (int i = 0; i < 24; i++) begin
			k = $unsigned($random(seed)) % 5;
			d = $random(seed);
			wr(12'h400 + 12'(k), d);
			mdl[k] = d[7:0] & msk[k];
			rchk({12'h400 + 12'(k), 2'b00}, {24'h0, mdl[k]}, 1'b0, "rdback");
			chk_outs();
		end
		wr(12'h400, 32'hff);
		mdl[0] = 8'h3f;
		chk_outs();
		rchk(14'h1040, 32'h0, 1'b1, "unmapped");
		rchk(14'h1001, 32'h0, 1'b1, "misalign");
		$display("test random done");
		// Every defined mode with both invert bits, output zero enabled
		wr(12'h400, 32'h0);
		wr(12'h401, 32'h1);
		for (int m = 0; m < 24; m++) begin
			md = 3'(m % 6);
			pol = 1'((m / 6) % 2);
			ph = 1'(m / 12);
			dist_clk <= m[1];
			wr(12'h404, {26'h0, ph, pol, pol, md});
			repeat (4) @(posedge pclk);
			`CHK("oe_pos", !(md == 0 || md == 1), zero_pos_oe_n)
			`CHK("oe_neg", !(md == 0 || md == 2), zero_neg_oe_n)
			`CHK("lvds", md == 4, zero_lvds)
			`CHK("lvpecl", md == 5, zero_lvpecl)
			`CHK("drive", pol, zero_drive_high)
			if (md < 2) `CHK("polarity", dist_clk ^ pol, pos_level)
			if (md == 0 && ph == 0) rel = pos_level ^ neg_level;
			if (md == 0 && ph == 1) `CHK("phase", ~rel, pos_level ^ neg_level)
		end
		wr(12'h401, 32'h0);
		@(posedge pclk);
		`CHK("oe_off", 3'b110, {zero_pos_oe_n, zero_neg_oe_n, zero_lvpecl})
		// Clock enable low must freeze the pass-through path
		rel = zero_pos_data;
		clk_en <= 1'b0;
		dist_clk <= ~dist_clk;
		repeat (6) @(posedge pclk);
		`CHK("freeze", rel, zero_pos_data)
		clk_en <= 1'b1;
		repeat (6) @(posedge pclk);
		`CHK("thaw", ~rel, zero_pos_data)
		$display("test modes done");
		sync_run(0, 0, 5, 0);
		sync_run(0, 0, 15, 0);
		sync_run(1, 0, 0, 1);
		sync_run(2, 0, 10, 2);
		sync_run(0, 1, 3, 3);
		sync_run(0, 2, 8, 4);
		sync_run(0, 0, 0, 3);
		sync_run(0, 1, 0, 4);
		$display("test sync done");
		end_sim();
	end
endmodule : tb_top
